// ==== hdl/static_mem_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module static_mem_ctrl
  import smc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // core request side
  input wire logic req_valid,
  input var req_s req,
  output logic req_ready,
  output logic rdata_valid,
  output logic [DATA_W-1:0] rdata,
  // configuration
  input var cfg_s cfg,
  // external memory side
  input wire logic expansion_ready_in,
  input wire logic [DATA_W-1:0] mem_din,
  output logic [DATA_W-1:0] mem_dout,
  output logic mem_dout_en,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_halfword,
  output logic mem_word,
  output logic mem_write,
  output logic chip_select_n,
  output logic mem_oe_n,
  output logic mem_we_n
);

  ////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // ready sampling on the falling edge
  // falling edge sample
  // asynchronous ready is caught by this falling-edge flop
  logic rdy_fall_q;
  always_ff @(negedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdy_fall_q <= 1'b0;
    else
      rdy_fall_q <= expansion_ready_in;
  end

  ////////////////////////////////////////////////////////////////
  // state and counters
  state_e state_q;
  state_e state_d;
  logic [WAIT_W-1:0] wait_q;
  logic [BURST_W-1:0] left_q;
  logic seq_q;
  logic xfer_done;

  // pick wait count; follow-on reads may use the sequential field
  function automatic logic [WAIT_W-1:0] pick_wait(input logic follow, input cfg_s c);
    if (follow && c.sequential_access_enable)
      pick_wait = c.seq_wait_states;
    else if (follow)
      pick_wait = WAIT_ZERO;
    else
      pick_wait = c.wait_states;
  endfunction : pick_wait

  // clamp requested burst length into its legal range
  function automatic logic [BURST_W-1:0] clamp_len(input logic [BURST_W-1:0] n);
    if (n < BURST_MIN)
      clamp_len = BURST_ONE;
    else if (n > BURST_MAX)
      clamp_len = BURST_MAX;
    else
      clamp_len = n;
  endfunction : clamp_len

  // complete only when count expired and ready high
  assign xfer_done = (state_q == ST_XFER) && rdy_fall_q;
  assign req_ready = (state_q == ST_IDLE);

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (req_valid)
          state_d = (pick_wait(1'b0, cfg) == WAIT_ZERO) ? ST_XFER : ST_WAIT;
      // programmed waits stretch by whole clocks
      ST_WAIT:
        if (wait_q == WAIT_ONE)
          state_d = ST_XFER;
      // ready low keeps us here another clock
      ST_XFER:
        if (rdy_fall_q)
        begin
          if (left_q > BURST_ONE)
            // next burst beat follows directly unless sequential access sets seq_wait_states
            state_d = (pick_wait(1'b1, cfg) == WAIT_ZERO) ? ST_XFER : ST_WAIT;
          else if (cfg.sequential_access_enable)
            state_d = ST_IDLE;
          else
            state_d = ST_GAP;
        end
      ST_GAP:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // wait counter and burst beats
  // burst run of two to four
  // first beat takes the normal wait, follow-on beats the sequential one, or none when sequential access is off
  // sequential wait field for follow-on reads
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wait_q <= WAIT_ZERO;
      left_q <= BURST_ONE;
      seq_q <= 1'b0;
    end
    else if (state_q == ST_IDLE && req_valid)
    begin
      wait_q <= pick_wait(1'b0, cfg);
      left_q <= req.write ? BURST_ONE : clamp_len(req.burst_len);
      seq_q <= 1'b0;
    end
    else if (state_q == ST_WAIT)
      wait_q <= wait_q - WAIT_ONE;
    else if (xfer_done && left_q > BURST_ONE)
    begin
      wait_q <= pick_wait(1'b1, cfg);
      left_q <= left_q - BURST_ONE;
      seq_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // address and qualifiers, held between accesses
  // hold until next access
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      mem_addr <= ADDR_RST;
      mem_halfword <= 1'b0;
      mem_word <= 1'b0;
      mem_write <= 1'b0;
      mem_dout <= DATA_RST;
    end
    else if (state_q == ST_IDLE && req_valid)
    begin
      mem_addr <= req.addr;
      mem_halfword <= req.halfword;
      mem_word <= req.word;
      mem_write <= req.write;
      mem_dout <= req.wdata;
    end
    else if (xfer_done && left_q > BURST_ONE)
      mem_addr <= mem_addr + ADDR_STEP;
  end

  // strobes; chip select spans the whole burst
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      chip_select_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_we_n <= 1'b1;
      mem_dout_en <= 1'b0;
    end
    else
    begin
      chip_select_n <= !(state_d == ST_WAIT || state_d == ST_XFER);
      mem_oe_n <= !((state_d == ST_WAIT || state_d == ST_XFER) && !mem_write_next());
      mem_we_n <= !((state_d == ST_WAIT || state_d == ST_XFER) && mem_write_next());
      mem_dout_en <= (state_d == ST_WAIT || state_d == ST_XFER) && mem_write_next();
    end
  end

  // direction of the access about to run
  function automatic logic mem_write_next();
    mem_write_next = (state_q == ST_IDLE) ? req.write : mem_write;
  endfunction : mem_write_next

  // read data capture
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rdata <= DATA_RST;
      rdata_valid <= 1'b0;
    end
    else
    begin
      rdata_valid <= xfer_done && !mem_write;
      if (xfer_done && !mem_write)
        rdata <= mem_din;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  // programmed wait never completes early
  wait_block_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
    (state_q == ST_WAIT) |-> !xfer_done)
    else $error("transfer during wait states");
  ready_low_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
    (state_q == ST_XFER && !rdy_fall_q) |=> (state_q == ST_XFER))
    else $error("ready low did not stall");
  done_cause_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
    xfer_done |-> (state_q == ST_XFER && rdy_fall_q))
    else $error("completion without ready");
  addr_hold_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
    (state_q == ST_IDLE && !req_valid) |=> $stable(mem_addr) && $stable(mem_write))
    else $error("address not held");
  burst_len_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
    left_q <= BURST_MAX)
    else $error("burst too long");
  // an over-long burst request is cut to the longest legal run
  burst_clamp_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
    (state_q == ST_IDLE && req_valid && !req.write && req.burst_len > BURST_MAX)
      |=> (left_q == BURST_MAX))
    else $error("burst length not clamped");
  // without sequential access a follow-on beat never waits
  follow_nowait_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
    (seq_q && !cfg.sequential_access_enable) |-> (state_q != ST_WAIT))
    else $error("follow-on beat took a wait");
  no_gap_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
    (xfer_done && cfg.sequential_access_enable) |=> (state_q != ST_GAP))
    else $error("idle gap with sequential access");
  seq_wait_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
    (xfer_done && left_q > BURST_ONE && cfg.sequential_access_enable)
      |=> (wait_q == $past(cfg.seq_wait_states)))
    else $error("wrong sequential wait");
  first_wait_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
    (state_q == ST_IDLE && req_valid && cfg.wait_states == WAIT_ONE) |=> (state_q == ST_WAIT))
    else $error("first beat missed its wait");
  read_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
    (xfer_done && !mem_write) |=> rdata_valid)
    else $error("read data not flagged");
endmodule : static_mem_ctrl
`default_nettype wire

// ==== inc/smc_pkg.sv ====
package smc_pkg;
  // widths of the bus side
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam int WAIT_W = 4;
  localparam int BURST_W = 3;
  // burst run limits
  localparam logic [BURST_W-1:0] BURST_MIN = 3'h2;
  localparam logic [BURST_W-1:0] BURST_MAX = 3'h4;
  localparam logic [BURST_W-1:0] BURST_ONE = 3'h1;
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
  localparam logic [WAIT_W-1:0] WAIT_ONE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 28'h0000004;
  localparam logic [ADDR_W-1:0] ADDR_RST = 28'h0000000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;

  // one access request from the core side
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic halfword;
    logic word;
    logic [BURST_W-1:0] burst_len;
    logic [DATA_W-1:0] wdata;
  } req_s;

  // wait configuration
  typedef struct packed {
    logic [WAIT_W-1:0] wait_states;
    logic [WAIT_W-1:0] seq_wait_states;
    logic sequential_access_enable;
  } cfg_s;

  // one-hot controller states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_XFER = 4'h4,
    ST_GAP = 4'h8
  } state_e;
endpackage : smc_pkg

// ==== verif/mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mem_model
  import smc_pkg::*;
(
  // memory bus side
  input wire logic mclk,
  input wire logic chip_select_n,
  input wire logic mem_oe_n,
  input wire logic [ADDR_W-1:0] mem_addr,
  // stall cycles per beat
  input wire logic [3:0] stall,
  output logic expansion_ready_in,
  output logic [DATA_W-1:0] mem_din
);
  logic [ADDR_W-1:0] last_q = ADDR_RST;
  logic [DATA_W-1:0] held_q = DATA_RST;
  logic [3:0] cnt_q = 4'h0;
  // ready moves just after the edge, not aligned to sampling
  assign expansion_ready_in = chip_select_n | (cnt_q >= stall);
  // released bus toggles so a stale value never passes
  assign mem_din = mem_oe_n ? ~held_q : {4'h5, mem_addr};
  // a new address restarts the stall count
  always @(posedge mclk)
  begin
    last_q <= mem_addr;
    held_q <= mem_din;
    cnt_q <= (chip_select_n || mem_addr !== last_q) ? 4'h0 : cnt_q + 4'h1;
  end
endmodule : mem_model
`default_nettype wire

// ==== verif/static_memory_wait_burst_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module static_memory_wait_burst_ctrl_test;
  import smc_pkg::*;
  logic mclk, nrst, req_valid, req_ready, rdata_valid, rdy, mem_dout_en;
  logic mem_halfword, mem_word, mem_write, chip_select_n, mem_oe_n, mem_we_n;
  logic [DATA_W-1:0] rdata, din, mem_dout;
  logic [ADDR_W-1:0] mem_addr;
  logic [3:0] stall;
  req_s req;
  cfg_s cfg;
  int err_count, comparisons, beats, first, gap, busy, f0, b0, f1, wbeats;
  int cyc = 0;

  static_mem_ctrl u_dut (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rdata_valid(rdata_valid), .rdata(rdata), .cfg(cfg),
    .expansion_ready_in(rdy), .mem_din(din), .mem_dout(mem_dout),
    .mem_dout_en(mem_dout_en), .mem_addr(mem_addr), .mem_halfword(mem_halfword),
    .mem_word(mem_word), .mem_write(mem_write), .chip_select_n(chip_select_n),
    .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n));
  mem_model u_mem (.mclk(mclk), .chip_select_n(chip_select_n), .mem_oe_n(mem_oe_n),
    .mem_addr(mem_addr), .stall(stall), .expansion_ready_in(rdy), .mem_din(din));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // hang guard, well above the planned run
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_count++;
      close_out();
    end
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task close_out;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  // one request, then 40 cycles of watching beats and the return of ready
  task acc(input logic [ADDR_W-1:0] a, input logic w, input logic [2:0] n);
    int t, lastv;
    logic [ADDR_W-1:0] ea;
    ea = a;
    req <= '{addr: a, write: w, halfword: w, word: !w, burst_len: n,
      wdata: {4'hC, a}};
    req_valid <= 1'b1;
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    {beats, first, gap, busy, t, lastv, wbeats} = '0;
    repeat (40)
    begin
      @(posedge mclk);
      t++;
      // a write strobe must carry the request's data on the driven bus
      if (mem_we_n === 1'b0)
      begin
        wbeats++;
        chk("wdata", {4'hC, a}, mem_dout);
        chk("dout_en", 1, mem_dout_en);
      end
      if (rdata_valid === 1'b1)
      begin
        chk("rdata", {4'h5, ea}, rdata);
        ea += ADDR_STEP;
        if (beats > 0) gap = t - lastv;
        else first = t;
        lastv = t;
        beats++;
      end
      if (busy == 0 && req_ready === 1'b1) busy = t;
    end
  endtask : acc

  initial
  begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    cfg = '0;
    stall = 4'h0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    acc(28'h0000100, 1'b0, 3'h1);
    f0 = first;
    b0 = busy;
    cfg.wait_states <= 4'h3;
    acc(28'h0000104, 1'b0, 3'h1);
    chk("wait latency", f0 + 3, first);
    cfg.wait_states <= WAIT_ZERO;
    stall <= 4'h1;
    acc(28'h0000108, 1'b0, 3'h1);
    f1 = first;
    stall <= 4'h2;
    acc(28'h000010C, 1'b0, 3'h1);
    chk("ready stretch", f1 + 1, first);
    stall <= 4'h0;
    $display("test waits done");
    // burst lengths below, inside and above the legal run
    cfg.wait_states <= WAIT_ONE;
    for (int n = 1; n <= 5; n++)
    begin
      acc(28'h0000200, 1'b0, n[2:0]);
      chk("beats", (n < 2) ? 1 : (n > 4) ? 4 : n, beats);
    end
    chk("burst gap", 1, gap);
    chk("addr hold", 28'h000020C, mem_addr);
    chk("word hold", 1, mem_word);
    chk("hw hold", 0, mem_halfword);
    // software turns sequential access on where the memory allows
    cfg.sequential_access_enable <= 1'b1;
    cfg.seq_wait_states <= 4'h2;
    acc(28'h0000300, 1'b0, 3'h4);
    chk("seq gap", 3, gap);
    cfg.wait_states <= WAIT_ZERO;
    acc(28'h0000400, 1'b0, 3'h1);
    chk("no idle", b0 - 1, busy);
    $display("test bursts done");
    // a write never bursts and leaves its direction standing
    acc(28'h0000500, 1'b1, 3'h4);
    chk("write beats", 0, beats);
    chk("write strobes", 1, wbeats);
    chk("dir hold", 1, mem_write);
    chk("hw hold", 1, mem_halfword);
    chk("word hold", 0, mem_word);
    chk("waddr hold", 28'h0000500, mem_addr);
    $display("test write done");
    close_out();
  end
endmodule : static_memory_wait_burst_ctrl_test
`default_nettype wire
